//--- logic/ssw_pkg.sv
// Package with constants and carrier types for the servo status word block
// Function
// - Bits 0-2 and 4-5 always read one
// - Bits 8 and 15 always read zero
// - Bit 3 shows servo or option alarm
// - Bit 6 power-on-prohibited always zero
// - Bit 7 shows servo warning
// - Bit 9 control request always one
// - Bit 10 set when droop below range
// - Bit 10 forced clear during base off
// - Bit 11 set after home return finishes
// - Absolute system: bit 11 follows servo-on state
// - Bit 11 cleared by stops, servo-off, alarm
// - Bit 11 waits new homing after loss events
// - Bit 11 cleared on direction/address change, homing
// - Bit 12 set when servo on, operable
// - Bit 13 set after amplifier initialization
// - Bit 14 set on operation alarm
package ssw_pkg;

  // ---------------------------------------------------------------
  // Word layout
  // ---------------------------------------------------------------
  localparam int SSW_WORD_W = 16;       // Status word width
  localparam int SSW_DROOP_W = 16;      // Droop count and range width
  localparam int SSW_BIT_FAULT = 3;     // Servo or option alarm
  localparam int SSW_BIT_PON_PROHIB = 6; // Power-on prohibited
  localparam int SSW_BIT_WARN = 7;      // Servo warning
  localparam int SSW_BIT_RSVD8 = 8;     // Fixed zero
  localparam int SSW_BIT_CTRL_REQ = 9;  // Control request
  localparam int SSW_BIT_INPOS = 10;    // In position
  localparam int SSW_BIT_HOME = 11;     // Home return complete
  localparam int SSW_BIT_SON = 12;      // Servo on status
  localparam int SSW_BIT_READY = 13;    // Amplifier ready
  localparam int SSW_BIT_OPERATION_ALARM_FLAG = 14;     // Operation alarm
  localparam int SSW_BIT_RSVD15 = 15;   // Fixed zero

  // Fixed bits: ones at 0..2, 4, 5 and 9; everything else starts at zero
  localparam logic [15:0] SSW_FIXED_ONES = 16'h0237;
  localparam logic [15:0] SSW_FIXED_MASK = 16'h8377;

  // ---------------------------------------------------------------
  // Reset values
  // ---------------------------------------------------------------
  localparam logic [15:0] SSW_WORD_RST = 16'h0000;  // Response word before first request
  localparam logic SSW_NEED_HOME_RST = 1'b1;        // First use needs a home return
  localparam logic SSW_HOMED_RST = 1'b0;            // Not homed after reset
  localparam logic SSW_ABS_EN_RST = 1'b0;           // Absolute system seen off after reset

  // ---------------------------------------------------------------
  // Carrier types
  // ---------------------------------------------------------------
  // Levels from the amplifier pins; synchronised inside the block
  typedef struct packed {
    logic servo_alarm;             // Servo amplifier alarm active
    logic option_alarm;            // Option unit alarm active
    logic servo_warning_flag;      // Servo warning active
    logic base_off;                // Amplifier in base-off state
    logic servo_on_input;          // Servo-on input asserted
    logic emergency_stop_circuit;  // High while the emergency stop circuit is open
    logic forced_stop_circuit;     // High while the forced stop circuit is open
    logic servo_on_state;          // Amplifier in servo-on state
    logic operation_possible;      // Motion operation possible
    logic init_done;               // Amplifier initialization completed
    logic operation_alarm;         // Operation alarm active
    logic abs_system_en;           // Absolute position system in use
  } ssw_levels_t;

  // Homing events from same-clock sequencer logic
  typedef struct packed {
    logic home_return_active;            // Level: home return in progress
    logic home_return_done;              // Pulse: home return finished
    logic absolute_position_lost_alarm;  // Pulse: absolute position lost
    logic absolute_counter_warning;      // Pulse: absolute counter warning
    logic gear_change;                   // Pulse: electronic gear changed
    logic direction_change;              // Pulse: rotation direction selection changed
    logic home_addr_change;              // Pulse: home position address changed
  } ssw_homing_t;

endpackage

//--- logic/ssw_sync2.sv
// Two-stage synchroniser for a bundle of independent levels
`timescale 1ns/100ps
module ssw_sync2 #(
  parameter int WIDTH = 1
) (
  input wire logic clock_in,
  input wire logic sys_rst_in,
  input wire logic [WIDTH-1:0] d_in,
  output logic [WIDTH-1:0] q_out
);

  // ---------------------------------------------------------------
  // Stages
  // ---------------------------------------------------------------
  logic [WIDTH-1:0] meta_r; // First stage, read only by the second

  // Each bit is its own level; no bus coherence is promised across bits
  always_ff @(posedge clock_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      meta_r <= '0;
      q_out <= '0;
    end else begin
      meta_r <= d_in;
      q_out <= meta_r;
    end
  end

endmodule

//--- logic/ssw_status_word.sv
// Status word builder returned with each command response
`timescale 1ns/100ps
module ssw_status_word (
  input wire logic clock_in,
  input wire logic sys_rst_in,
  input wire ssw_pkg::ssw_levels_t levels_in,
  input wire ssw_pkg::ssw_homing_t homing_in,
  input wire logic [15:0] droop_pulses_in,
  input wire logic [15:0] inpos_range_in,
  input wire logic response_req_in,
  output logic [15:0] status_word_out,
  output logic response_valid_out
);

  // ---------------------------------------------------------------
  // Input synchronisation
  // ---------------------------------------------------------------
  logic [$bits(ssw_pkg::ssw_levels_t)-1:0] lv_vec; // Synchronised levels as a vector
  ssw_pkg::ssw_levels_t lv;                         // Synchronised levels

  // Pin levels are asynchronous to our clock, so all pass two stages
  ssw_sync2 #(
    .WIDTH($bits(ssw_pkg::ssw_levels_t))
  ) u_sync (
    .clock_in(clock_in),
    .sys_rst_in(sys_rst_in),
    .d_in(levels_in),
    .q_out(lv_vec)
  );

  assign lv = lv_vec;

  // ---------------------------------------------------------------
  // Homing state
  // ---------------------------------------------------------------
  logic need_home_r;   // A fresh home return is owed
  logic need_home_nxt;
  logic homed_r;       // Incremental-mode home return latched
  logic homed_nxt;
  logic abs_en_d_r;    // Previous absolute-enable level for edge detect
  logic abs_en_d_nxt;
  logic loss_event;    // Any event that voids the home position
  logic level_clear;   // Conditions that hold the flag clear
  logic home_flag;     // Home-return-complete as currently seen

  // Events that void the home position, including turning on the absolute system
  always_comb begin
    loss_event = homing_in.absolute_position_lost_alarm | homing_in.absolute_counter_warning
               | homing_in.gear_change | (lv.abs_system_en & ~abs_en_d_r)
               | homing_in.direction_change | homing_in.home_addr_change;
  end

  // Conditions under which the flag reads zero whatever the latches say
  always_comb begin
    level_clear = ~lv.servo_on_input | lv.emergency_stop_circuit | lv.forced_stop_circuit
                | lv.servo_alarm | lv.option_alarm
                | homing_in.home_return_active;
  end

  // Next values of the homing latches
  always_comb begin
    abs_en_d_nxt = lv.abs_system_en;
    // A voiding event wins over a completion in the same cycle
    if (loss_event) begin
      need_home_nxt = 1'b1;
    end else if (homing_in.home_return_done) begin
      need_home_nxt = 1'b0;
    end else begin
      need_home_nxt = need_home_r;
    end
    // Completion is the set and wins over a level clear arriving with it, but not over a voiding event
    if (homing_in.home_return_done & ~loss_event) begin
      homed_nxt = 1'b1;
    end else if (loss_event | level_clear) begin
      homed_nxt = 1'b0;
    end else begin
      homed_nxt = homed_r;
    end
  end

  // Registers of the homing latches; first use owes a home return
  always_ff @(posedge clock_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      need_home_r <= ssw_pkg::SSW_NEED_HOME_RST;
      homed_r <= ssw_pkg::SSW_HOMED_RST;
      abs_en_d_r <= ssw_pkg::SSW_ABS_EN_RST;
    end else begin
      need_home_r <= need_home_nxt;
      homed_r <= homed_nxt;
      abs_en_d_r <= abs_en_d_nxt;
    end
  end

  // Flag selection: absolute system follows servo-on, otherwise the latch
  // A voiding event masks the flag in its own cycle too, before the latches catch up,
  // so a response taken right at the event never reports a stale home position
  always_comb begin
    if (lv.abs_system_en) begin
      home_flag = lv.servo_on_state & ~need_home_r & ~level_clear & ~loss_event;
    end else begin
      home_flag = homed_r & ~level_clear & ~loss_event;
    end
  end

  // ---------------------------------------------------------------
  // Word assembly
  // ---------------------------------------------------------------
  logic [15:0] word_now;  // Word built from the present state
  logic in_position;      // Droop inside in-position range

  // Strictly below the range; base off forces it clear
  always_comb begin
    in_position = (droop_pulses_in < inpos_range_in) & ~lv.base_off;
  end

  // Fixed bits first, then the live flags on top
  always_comb begin
    word_now = ssw_pkg::SSW_FIXED_ONES;
    word_now[ssw_pkg::SSW_BIT_FAULT] = lv.servo_alarm | lv.option_alarm;
    word_now[ssw_pkg::SSW_BIT_WARN] = lv.servo_warning_flag;
    word_now[ssw_pkg::SSW_BIT_INPOS] = in_position;
    word_now[ssw_pkg::SSW_BIT_HOME] = home_flag;
    word_now[ssw_pkg::SSW_BIT_SON] = lv.servo_on_state & lv.operation_possible;
    word_now[ssw_pkg::SSW_BIT_READY] = lv.init_done;
    word_now[ssw_pkg::SSW_BIT_OPERATION_ALARM_FLAG] = lv.operation_alarm;
  end

  // ---------------------------------------------------------------
  // Response register
  // ---------------------------------------------------------------
  logic [15:0] word_nxt;  // Next response word
  logic valid_nxt;        // Next response strobe

  // Capture only on a request so the master sees one coherent snapshot
  always_comb begin
    valid_nxt = response_req_in;
    if (response_req_in) begin
      word_nxt = word_now;
    end else begin
      word_nxt = status_word_out;
    end
  end

  // Registered outputs
  always_ff @(posedge clock_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      status_word_out <= ssw_pkg::SSW_WORD_RST;
      response_valid_out <= 1'b0;
    end else begin
      status_word_out <= word_nxt;
      response_valid_out <= valid_nxt;
    end
  end

  // ---------------------------------------------------------------
  // Assertions
  // ---------------------------------------------------------------
  // All checks live in the one clock domain; reset silences them
  default clocking cb @(posedge clock_in); endclocking
  default disable iff (sys_rst_in);

  // Fixed ones at bits 0..2, 4 and 5 present in every response
  property p_fixed_ones;
    response_valid_out |-> (status_word_out[2:0] == 3'h7) && (status_word_out[5:4] == 2'h3);
  endproperty
  a_fixed_ones: assert property (p_fixed_ones) else $error("fixed one bits wrong");

  // Fixed zeros at bits 8 and 15 always present
  property p_fixed_zeros;
    response_valid_out |-> !status_word_out[8] && !status_word_out[15];
  endproperty
  a_fixed_zeros: assert property (p_fixed_zeros) else $error("fixed zero bits wrong");

  // Fault tracks alarms at the sampling edge
  property p_fault;
    response_req_in |=> status_word_out[3] == ($past(lv.servo_alarm) | $past(lv.option_alarm));
  endproperty
  a_fault: assert property (p_fault) else $error("fault bit mismatch");

  // Power-on prohibited never shown
  property p_pon;
    response_valid_out |-> !status_word_out[6];
  endproperty
  a_pon: assert property (p_pon) else $error("power-on prohibited set");

  // Warning follows the synchronised warning level
  property p_warn;
    response_req_in |=> status_word_out[7] == $past(lv.servo_warning_flag);
  endproperty
  a_warn: assert property (p_warn) else $error("warning bit mismatch");

  // Control request always shown
  property p_ctrl;
    response_valid_out |-> status_word_out[9];
  endproperty
  a_ctrl: assert property (p_ctrl) else $error("control request clear");

  // In position tied to droop compare
  property p_inpos;
    response_req_in && !lv.base_off
      |=> status_word_out[10] == ($past(droop_pulses_in) < $past(inpos_range_in));
  endproperty
  a_inpos: assert property (p_inpos) else $error("in-position mismatch");

  // Base off forces in-position clear
  property p_baseoff;
    response_req_in && lv.base_off |=> !status_word_out[10];
  endproperty
  a_baseoff: assert property (p_baseoff) else $error("in-position set in base off");

  // Completion in incremental mode latches the flag one cycle later
  property p_homed;
    homing_in.home_return_done && !loss_event ##1 !lv.abs_system_en && !level_clear && !loss_event |-> home_flag;
  endproperty
  a_homed: assert property (p_homed) else $error("home flag not set after return");

  // Absolute mode follows servo-on when nothing is owed
  property p_abs;
    lv.abs_system_en && !need_home_r && !level_clear && !loss_event |-> home_flag == lv.servo_on_state;
  endproperty
  a_abs: assert property (p_abs) else $error("absolute home flag mismatch");

  // Servo-off and stops clear the response bit
  property p_clear;
    response_req_in && (!lv.servo_on_input || lv.emergency_stop_circuit || lv.forced_stop_circuit)
      |=> !status_word_out[11];
  endproperty
  a_clear: assert property (p_clear) else $error("home flag set while stopped");

  // A voiding event keeps the absolute-mode flag clear in the next cycle unless a return finishes
  property p_loss;
    loss_event && !homing_in.home_return_done ##1 lv.abs_system_en && !homing_in.home_return_done
      |-> !home_flag;
  endproperty
  a_loss: assert property (p_loss) else $error("home flag set after loss event");

  // Flag clear during home return
  property p_active;
    homing_in.home_return_active |-> !home_flag;
  endproperty
  a_active: assert property (p_active) else $error("home flag set during return");

  // A voiding event clears the flag in the very cycle it arrives
  property p_loss_now;
    loss_event |-> !home_flag;
  endproperty
  a_loss_now: assert property (p_loss_now) else $error("home flag set at loss event");

  // An owed home return keeps the absolute-mode flag clear
  property p_abs_need;
    lv.abs_system_en && need_home_r |-> !home_flag;
  endproperty
  a_abs_need: assert property (p_abs_need) else $error("home flag set while return owed");

  // Absolute mode shows nothing while the amplifier is not servo-on
  property p_abs_off;
    lv.abs_system_en && !lv.servo_on_state |-> !home_flag;
  endproperty
  a_abs_off: assert property (p_abs_off) else $error("home flag set without servo on");

  // A servo or option alarm clears the flag at once
  property p_alarm_home;
    lv.servo_alarm || lv.option_alarm |-> !home_flag;
  endproperty
  a_alarm_home: assert property (p_alarm_home) else $error("home flag set during alarm");

  // A clearing condition drops the incremental latch unless a return just finished
  property p_homed_drop;
    level_clear && !homing_in.home_return_done |=> !homed_r;
  endproperty
  a_homed_drop: assert property (p_homed_drop) else $error("home latch kept through clear");

  // A finished return with no voiding event settles the debt
  property p_need_done;
    homing_in.home_return_done && !loss_event |=> !need_home_r;
  endproperty
  a_need_done: assert property (p_need_done) else $error("home return still owed after done");

  // Remaining status bits follow their sources
  property p_status_bits;
    response_req_in |=> status_word_out[12] == $past(lv.servo_on_state & lv.operation_possible)
      && status_word_out[13] == $past(lv.init_done) && status_word_out[14] == $past(lv.operation_alarm);
  endproperty
  a_status_bits: assert property (p_status_bits) else $error("status bit mismatch");

  // Every request yields a strobe and a fresh word; no request keeps the word
  property p_fresh;
    response_req_in |=> response_valid_out && status_word_out == $past(word_now);
  endproperty
  a_fresh: assert property (p_fresh) else $error("response not fresh");

  // A quiet cycle keeps the last snapshot for the master
  property p_hold;
    !response_req_in |=> !response_valid_out && $stable(status_word_out);
  endproperty
  a_hold: assert property (p_hold) else $error("word changed without request");

  // The strobe only ever answers a request of the cycle before
  property p_valid_only;
    response_valid_out |-> $past(response_req_in);
  endproperty
  a_valid_only: assert property (p_valid_only) else $error("strobe without request");

  // Main scenarios
  c_homed: cover property (response_valid_out && status_word_out[11] && !lv.abs_system_en);
  c_abs_homed: cover property (response_valid_out && status_word_out[11] && lv.abs_system_en);
  c_fault: cover property (response_valid_out && status_word_out[3]);
  c_inpos: cover property (response_valid_out && status_word_out[10]);
  c_owed: cover property (response_valid_out && lv.abs_system_en && need_home_r);

endmodule

//--- test/ssw_master_model.sv
// Fieldbus master model that polls the status word and keeps the last answer
`timescale 1ns/100ps
module ssw_master_model (
  input wire logic clock_in,
  input wire logic sys_rst_in,
  input wire logic poll_in,
  input wire logic [15:0] status_word_in,
  input wire logic response_valid_in,
  output logic response_req_out,
  output logic [15:0] last_word_out,
  output int answers_out
);
  // ---------------------------------------------------------------
  // Request side
  // ---------------------------------------------------------------
  // Poll level from the bench is the request; held high means one per cycle
  assign response_req_out = poll_in;

  // ---------------------------------------------------------------
  // Answer capture
  // ---------------------------------------------------------------
  // Only the cycle with valid is trusted; the word may move after it
  always_ff @(posedge clock_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      last_word_out <= 16'h0000;
      answers_out <= 0;
    end else if (response_valid_in === 1'b1) begin
      last_word_out <= status_word_in;
      answers_out <= answers_out + 1;
    end
  end
endmodule

//--- test/tb_top.sv
// Self-checking bench for the status word builder
`timescale 1ns/100ps
`define CHK(g, x, m) begin checked++; if ((g) !== (x)) begin fails++; \
  $display("wrong value at %0t: %s got %0h exp %0h", $time, m, g, x); end end
module tb_top;
  // ---------------------------------------------------------------
  // Signals and model state
  // ---------------------------------------------------------------
  logic clock_in = 1'b0;
  logic sys_rst_in = 1'b1;
  ssw_pkg::ssw_levels_t lv = '0; // Amplifier levels
  ssw_pkg::ssw_homing_t hm = '0; // Homing events
  logic [15:0] drp = 16'h0000; // Droop count
  logic [15:0] rng = 16'h0000; // In-position range
  logic poll = 1'b0; // Poll level to the master model
  logic req;
  logic [15:0] word;
  logic valid;
  logic [15:0] last_word;
  int answers;
  int fails = 0;
  int checked = 0;
  int cycles = 0;
  int reqs = 0;
  logic [31:0] seed = 32'h0000_0043; // Fixed seed
  bit need_home = 1'b1; // Model: absolute system waits for a homing
  bit homed = 1'b0; // Model: incremental homing latch
  logic [15:0] e; // Last expected word

  ssw_master_model ssw_master_model_inst (.clock_in(clock_in), .sys_rst_in(sys_rst_in), .poll_in(poll),
    .status_word_in(word), .response_valid_in(valid), .response_req_out(req), .last_word_out(last_word),
    .answers_out(answers));
  ssw_status_word ssw_status_word_inst (.clock_in(clock_in), .sys_rst_in(sys_rst_in), .levels_in(lv),
    .homing_in(hm), .droop_pulses_in(drp), .inpos_range_in(rng), .response_req_in(req),
    .status_word_out(word), .response_valid_out(valid));

  // ---------------------------------------------------------------
  // Clock and hang guard
  // ---------------------------------------------------------------
  initial begin
    forever #2 clock_in = ~clock_in;
  end

  // Run needs well under a thousand cycles; the ceiling leaves a wide margin
  always @(posedge clock_in) begin
    cycles++;
    if (cycles == 5000) begin
      fails++;
      $display("wrong value at %0t: run did not finish", $time);
      end_sim();
    end
  end

  // ---------------------------------------------------------------
  // Random source and behavioural model
  // ---------------------------------------------------------------
  function automatic logic [31:0] xs();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction

  // Any condition that keeps the home flag low
  function automatic bit clr_now();
    return !lv.servo_on_input || lv.emergency_stop_circuit || lv.forced_stop_circuit ||
      lv.servo_alarm || lv.option_alarm || hm.home_return_active;
  endfunction

  function automatic logic [15:0] model_word();
    logic [15:0] w;
    w = 16'h0237;
    w[3] = lv.servo_alarm | lv.option_alarm;
    w[7] = lv.servo_warning_flag;
    w[10] = !lv.base_off && (drp < rng);
    w[11] = !clr_now() && (lv.abs_system_en ? (lv.servo_on_state && !need_home) : homed);
    w[12] = lv.servo_on_state & lv.operation_possible;
    w[13] = lv.init_done;
    w[14] = lv.operation_alarm;
    return w;
  endfunction

  // ---------------------------------------------------------------
  // Stimulus tasks
  // ---------------------------------------------------------------
  // Levels are synchronised, so they settle four cycles before any use
  task automatic set_lv(input ssw_pkg::ssw_levels_t v);
    bit was_abs;
    was_abs = lv.abs_system_en;
    lv = v;
    if (clr_now()) homed = 1'b0;
    if (v.abs_system_en && !was_abs) begin
      need_home = 1'b1;
      homed = 1'b0;
    end
    repeat (4) @(posedge clock_in);
    #1;
  endtask

  // One-cycle homing event; a loss event beats a finished return
  task automatic pulse(input logic [6:0] p);
    hm = p;
    if (p[4:0] != 5'h00) begin
      need_home = 1'b1;
      homed = 1'b0;
    end else if (p[5]) begin
      need_home = 1'b0;
      homed = 1'b1;
    end
    @(posedge clock_in);
    #1;
    hm = '0;
    if (clr_now()) homed = 1'b0;
    @(posedge clock_in);
    #1;
  endtask

  // Back-to-back requests; range walks below, at and above the droop
  task automatic burst(input int n);
    logic [31:0] r;
    for (int k = 0; k < n; k++) begin
      r = xs();
      drp = r[15:0];
      rng = drp + 16'(k - 1);
      e = model_word();
      poll = 1'b1;
      @(posedge clock_in);
      #1;
      reqs++;
      `CHK(valid, 1'b1, "valid pulse");
      `CHK(word, e, "status word");
      `CHK(word[10], e[10], "in position");
      `CHK(word[11], e[11], "home complete");
    end
    poll = 1'b0;
    @(posedge clock_in);
    #1;
    `CHK(valid, 1'b0, "valid drop");
    `CHK(word, e, "word hold");
  endtask

  task automatic end_sim();
    $display("checked %0d fails %0d", checked, fails);
    if (fails == 0 && checked > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  // ---------------------------------------------------------------
  // Main sequence: incremental half first, then the absolute system
  // ---------------------------------------------------------------
  // Absolute mode is never left again, so the incremental latch stays unambiguous
  initial begin
    logic [31:0] r;
    ssw_pkg::ssw_levels_t v;
    repeat (4) @(posedge clock_in);
    #1;
    sys_rst_in = 1'b0;
    `CHK(word, 16'h0000, "reset word");
    `CHK(valid, 1'b0, "reset valid");
    for (int i = 0; i < 24; i++) begin
      r = xs();
      v = r[11:0];
      v.abs_system_en = (i >= 12);
      if (i[0]) begin
        v.servo_on_input = 1'b1;
        v.emergency_stop_circuit = 1'b0;
        v.forced_stop_circuit = 1'b0;
        v.servo_alarm = 1'b0;
        v.option_alarm = 1'b0;
      end
      set_lv(v);
      burst(2);
      if (i % 4 == 1) begin
        hm.home_return_active = 1'b1;
        homed = 1'b0;
        burst(1);
      end
      r = xs();
      pulse({2'b01, (i % 3 == 0) ? r[4:0] : 5'h00});
      burst(3);
    end
    `CHK(answers, reqs, "answer count");
    `CHK(last_word, word, "captured word");
    end_sim();
  end
endmodule
